// [hlf_pkg.sv]
package hlf_pkg;

  // ****************************************
  // Clock and line rate
  // ****************************************
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned LINE_BAUD = 38400;
  localparam logic [15:0] BAUD_DIV_DEF = 16'(CLK_HZ / LINE_BAUD);
  localparam logic [3:0] BITS_PER_CHAR = 4'hA;
  localparam logic [3:0] STOP_SLOT = 4'h1;

  // Reply timeout: time in ms and derived cycle count
  localparam int unsigned RSP_TMO_MS = 100;
  localparam int unsigned RSP_TMO_CYC = CLK_HZ / 1000 * RSP_TMO_MS;

  // ****************************************
  // Framing characters
  // ****************************************
  localparam logic [7:0] CH_ENQ = 8'h05;
  localparam logic [7:0] CH_AT = 8'h40;
  localparam logic [7:0] CH_STAR = 8'h2A;
  localparam logic [7:0] CH_CR = 8'h0D;

  // ****************************************
  // Command buffer and reply layout
  // ****************************************
  localparam int unsigned BUF_AW = 6;
  localparam int unsigned BUF_DEPTH = 1 << BUF_AW;
  localparam logic [7:0] POS_MP_AT = 8'h00;
  localparam logic [7:0] POS_MP_IDH = 8'h01;
  localparam logic [7:0] POS_MP_IDL = 8'h02;
  localparam logic [7:0] POS_MP_HDR = 8'h03;
  localparam logic [7:0] POS_PP_HDR = 8'h00;
  localparam logic [7:0] HDR_LEN = 8'h02;
  localparam logic [7:0] POS_MAX = 8'hFF;

  // Transmit sequence slots
  localparam logic [2:0] SQ_AT = 3'h0;
  localparam logic [2:0] SQ_IDH = 3'h1;
  localparam logic [2:0] SQ_IDL = 3'h2;
  localparam logic [2:0] SQ_BODY = 3'h3;
  localparam logic [2:0] SQ_FCSH = 3'h4;
  localparam logic [2:0] SQ_FCSL = 3'h5;
  localparam logic [2:0] SQ_STAR = 3'h6;
  localparam logic [2:0] SQ_CR = 3'h7;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ENQ = 3'h1,
    ST_ENQW = 3'h3,
    ST_SEND = 3'h2,
    ST_RECV = 3'h6
  } hlf_state_type;

  // Nibble to upper-case ASCII hex digit
  function automatic logic [7:0] nib2hex(input logic [3:0] n);
    nib2hex = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction : nib2hex

  // ASCII hex digit to nibble; lower case accepted
  function automatic logic [3:0] hex2nib(input logic [7:0] c);
    if (c >= 8'h61) begin
      hex2nib = 4'(c - 8'h57);
    end else if (c >= 8'h41) begin
      hex2nib = 4'(c - 8'h37);
    end else begin
      hex2nib = 4'(c - 8'h30);
    end
  endfunction : hex2nib

endpackage : hlf_pkg

// [hlf_buf.sv]
`timescale 1ns/1ns
module hlf_buf (
  input wire logic clk,
  input wire logic we,
  input wire logic [hlf_pkg::BUF_AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [hlf_pkg::BUF_AW-1:0] raddr,
  output logic [7:0] rdata
);
  import hlf_pkg::*;

  logic [7:0] mem [BUF_DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : hlf_buf

// [hlf_host.sv]
`timescale 1ns/1ns
// Behaviour
// - Line defaults to 38400 baud 8N1; rate changeable through baud_div.
// - Point-to-point frame: two-char header, ASCII data, then '*' and CR.
// - Binary values travel as two ASCII hex characters, 00 to FF.
// - Host opens a point-to-point session by sending Ctrl-E (05h).
// - Device echoes Ctrl-E when ready; host waits for that echo.
// - After the echo host sends its frame at once, then awaits reply.
// - Multi-point frame: '@', two-hex station ID, ..., two-char check, terminator.
// - Check value is XOR of all characters from '@' to last data char.
// - Multi-point host sends no Ctrl-E; single command/reply exchange.
// - Every station on a shared line has a distinct ID.
module hlf_host #(
  parameter int unsigned TMO_CYC = hlf_pkg::RSP_TMO_CYC
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [15:0] baud_div,
  input wire logic start,
  input wire logic mode_multi,
  input wire logic [7:0] station_id,
  input wire logic cmd_we,
  input wire logic [7:0] cmd_wdata,
  input wire logic ser_rx,
  output logic ser_tx,
  output logic ser_tx_oe,
  output logic busy,
  output logic done,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_ok,
  output logic err_rsp,
  output logic err_fcs,
  output logic err_tmo
);
  import hlf_pkg::*;

  hlf_state_type state_r;
  logic [2:0] seq_r;
  logic [BUF_AW-1:0] wptr_r, bidx_r;
  logic [7:0] buf_q, fcs_r, id_r, hdr0_r, hdr1_r;
  logic multi_r;
  logic [9:0] tx_sh_r;
  logic [3:0] tx_left_r, rx_left_r;
  logic [15:0] tx_cnt_r, rx_cnt_r;
  logic rx_m_r, rx_s_r, rx_v_r;
  logic [7:0] rx_sh_r, pos_r, rxx_r, h1_r, h2_r;
  logic hbad_r, star_r;
  logic [31:0] tmo_r;

  // ****************************************
  // Command buffer
  // ****************************************
  hlf_buf u_buf (
    .clk(mclk),
    .we(cmd_we & ~busy),
    .waddr(wptr_r),
    .wdata(cmd_wdata),
    .raddr(bidx_r),
    .rdata(buf_q)
  );

  // ****************************************
  // Decode
  // ****************************************
  wire tx_idle = (tx_left_r == 4'h0);
  wire [15:0] bit_last = baud_div - 16'h0001;
  wire sending = (state_r == ST_SEND);
  wire tx_load = (sending | (state_r == ST_ENQ)) & tx_idle;
  wire body_empty = (wptr_r == '0);
  wire body_last = (bidx_r + 1'b1 == wptr_r);
  wire [2:0] after_body = multi_r ? SQ_FCSH : SQ_STAR;
  wire [2:0] after_id = body_empty ? after_body : SQ_BODY;
  wire in_fcs = (seq_r == SQ_AT) | (seq_r == SQ_IDH) | (seq_r == SQ_IDL) | (seq_r == SQ_BODY);
  wire [7:0] tx_char =
    (state_r == ST_ENQ) ? CH_ENQ :
    (seq_r == SQ_AT) ? CH_AT :
    (seq_r == SQ_IDH) ? nib2hex(id_r[7:4]) :
    (seq_r == SQ_IDL) ? nib2hex(id_r[3:0]) :
    (seq_r == SQ_BODY) ? buf_q :
    (seq_r == SQ_FCSH) ? nib2hex(fcs_r[7:4]) :
    (seq_r == SQ_FCSL) ? nib2hex(fcs_r[3:0]) :
    (seq_r == SQ_STAR) ? CH_STAR : CH_CR;
  wire tmo_hit = (tmo_r == 32'(TMO_CYC - 1));
  wire enq_echo = rx_v_r & (rx_sh_r == CH_ENQ) & (state_r == ST_ENQW);
  wire rx_in = rx_v_r & (state_r == ST_RECV);
  wire rx_star = rx_in & (rx_sh_r == CH_STAR);
  wire rx_end = rx_in & (rx_sh_r == CH_CR) & star_r;
  wire rx_dat = rx_in & ~rx_star & ~rx_end;
  // Expected reply character at each header position
  wire [7:0] hdr_base = multi_r ? POS_MP_HDR : POS_PP_HDR;
  wire chk_en = (multi_r & (pos_r < POS_MP_HDR)) | (pos_r == hdr_base) | (pos_r == hdr_base + 8'h01);
  wire [7:0] exp_c =
    (multi_r & (pos_r == POS_MP_AT)) ? CH_AT :
    (multi_r & (pos_r == POS_MP_IDH)) ? nib2hex(id_r[7:4]) :
    (multi_r & (pos_r == POS_MP_IDL)) ? nib2hex(id_r[3:0]) :
    (pos_r == hdr_base) ? hdr0_r : hdr1_r;
  wire hdr_miss = rx_dat & chk_en & (rx_sh_r != exp_c);
  wire [7:0] rx_calc = rxx_r ^ h1_r ^ h2_r;
  wire [7:0] rx_got = {hex2nib(h2_r), hex2nib(h1_r)};
  wire short_rsp = (pos_r < hdr_base + HDR_LEN + (multi_r ? HDR_LEN : 8'h00));
  wire bad_rsp = hbad_r | short_rsp;
  wire bad_fcs = multi_r & ~bad_rsp & (rx_got != rx_calc);
  wire fin_tmo = ((state_r == ST_ENQW) | (state_r == ST_RECV)) & tmo_hit & ~rx_end;

  // ****************************************
  // Transmitter, 8N1
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      tx_sh_r <= '0;
      tx_left_r <= '0;
      tx_cnt_r <= '0;
      ser_tx <= 1'b1;
      ser_tx_oe <= 1'b0;
    end else begin
      ser_tx_oe <= tx_load | ~tx_idle;
      if (tx_load) begin
        ser_tx <= 1'b0;
        tx_sh_r <= {1'b1, 1'b1, tx_char};
        tx_left_r <= BITS_PER_CHAR;
        tx_cnt_r <= bit_last;
      end else if (!tx_idle) begin
        if (tx_cnt_r == '0) begin
          tx_cnt_r <= bit_last;
          tx_left_r <= tx_left_r - 4'h1;
          ser_tx <= tx_sh_r[0];
          tx_sh_r <= {1'b1, tx_sh_r[9:1]};
        end else begin
          tx_cnt_r <= tx_cnt_r - 16'h0001;
        end
      end
    end
  end

  // ****************************************
  // Receiver, mid-bit sampling
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rx_m_r <= 1'b1;
      rx_s_r <= 1'b1;
      rx_left_r <= '0;
      rx_cnt_r <= '0;
      rx_sh_r <= '0;
      rx_v_r <= 1'b0;
    end else begin
      rx_m_r <= ser_rx;
      rx_s_r <= rx_m_r;
      rx_v_r <= 1'b0;
      if (rx_left_r == '0) begin
        if (!rx_s_r) begin
          rx_left_r <= BITS_PER_CHAR;
          rx_cnt_r <= {1'b0, baud_div[15:1]};
        end
      end else if (rx_cnt_r != '0) begin
        rx_cnt_r <= rx_cnt_r - 16'h0001;
      end else begin
        rx_cnt_r <= bit_last;
        // A glitch that is high again at mid start bit is dropped
        rx_left_r <= (rx_left_r == BITS_PER_CHAR && rx_s_r) ? 4'h0 : rx_left_r - 4'h1;
        if (rx_left_r == STOP_SLOT) begin
          rx_v_r <= rx_s_r;
        end else if (rx_left_r != BITS_PER_CHAR) begin
          rx_sh_r <= {rx_s_r, rx_sh_r[7:1]};
        end
      end
    end
  end

  // ****************************************
  // Session sequencer
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      seq_r <= SQ_AT;
      wptr_r <= '0;
      bidx_r <= '0;
      fcs_r <= '0;
      id_r <= '0;
      hdr0_r <= '0;
      hdr1_r <= '0;
      multi_r <= 1'b0;
      tmo_r <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      rsp_ok <= 1'b0;
      err_rsp <= 1'b0;
      err_fcs <= 1'b0;
      err_tmo <= 1'b0;
    end else begin
      done <= 1'b0;
      tmo_r <= (rx_v_r | tmo_hit) ? '0 : tmo_r + 32'h1;
      unique case (state_r)
        ST_IDLE: begin
          if (cmd_we) begin
            wptr_r <= wptr_r + 1'b1;
          end
          if (start) begin
            busy <= 1'b1;
            multi_r <= mode_multi;
            id_r <= station_id;
            bidx_r <= '0;
            fcs_r <= '0;
            tmo_r <= '0;
            {rsp_ok, err_rsp, err_fcs, err_tmo} <= 4'h0;
            seq_r <= mode_multi ? SQ_AT : after_id;
            state_r <= mode_multi ? ST_SEND : ST_ENQ;
          end
        end
        ST_ENQ: begin
          tmo_r <= '0;
          state_r <= ST_ENQW;
        end
        ST_ENQW: begin
          if (enq_echo) begin
            state_r <= ST_SEND;
          end
        end
        ST_SEND: begin
          tmo_r <= '0;
          if (tx_load) begin
            if (in_fcs) begin
              fcs_r <= fcs_r ^ tx_char;
            end
            unique case (seq_r)
              SQ_AT: seq_r <= SQ_IDH;
              SQ_IDH: seq_r <= SQ_IDL;
              SQ_IDL: seq_r <= after_id;
              SQ_BODY: begin
                if (bidx_r == '0) begin
                  hdr0_r <= tx_char;
                end
                if (bidx_r == BUF_AW'(1)) begin
                  hdr1_r <= tx_char;
                end
                bidx_r <= bidx_r + 1'b1;
                seq_r <= body_last ? after_body : SQ_BODY;
              end
              SQ_FCSH: seq_r <= SQ_FCSL;
              SQ_FCSL: seq_r <= SQ_STAR;
              SQ_STAR: seq_r <= SQ_CR;
              SQ_CR: state_r <= ST_RECV;
            endcase
          end
        end
        ST_RECV: begin
          if (rx_end) begin
            rsp_ok <= ~bad_rsp & ~bad_fcs;
            err_rsp <= bad_rsp;
            err_fcs <= bad_fcs;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
      if (rx_end | fin_tmo) begin
        err_tmo <= fin_tmo;
        done <= 1'b1;
        busy <= 1'b0;
        wptr_r <= '0;
        state_r <= ST_IDLE;
      end
    end
  end

  // ****************************************
  // Reply parser
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pos_r <= '0;
      rxx_r <= '0;
      h1_r <= '0;
      h2_r <= '0;
      hbad_r <= 1'b0;
      star_r <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
    end else begin
      rsp_valid <= rx_dat;
      if (sending) begin
        pos_r <= '0;
        rxx_r <= '0;
        h1_r <= '0;
        h2_r <= '0;
        hbad_r <= 1'b0;
        star_r <= 1'b0;
      end else if (rx_in) begin
        star_r <= rx_star;
        if (rx_dat) begin
          rsp_data <= rx_sh_r;
          pos_r <= (pos_r == POS_MAX) ? pos_r : pos_r + 8'h01;
          rxx_r <= rxx_r ^ rx_sh_r;
          h2_r <= h1_r;
          h1_r <= rx_sh_r;
          hbad_r <= hbad_r | hdr_miss;
        end
      end
    end
  end

endmodule : hlf_host

// [hlf_chk_asserts.sv]
`timescale 1ns/1ns
module hlf_chk_asserts #(
  parameter int unsigned TMO_CYC = 2500000
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [15:0] baud_div,
  input wire logic start,
  input wire logic mode_multi,
  input wire logic [7:0] station_id,
  input wire logic cmd_we,
  input wire logic [7:0] cmd_wdata,
  input wire logic ser_rx,
  input wire logic ser_tx,
  input wire logic ser_tx_oe,
  input wire logic busy,
  input wire logic done,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_ok,
  input wire logic err_rsp,
  input wire logic err_fcs,
  input wire logic err_tmo
);
  // ****************************************
  // Session tracking
  // ****************************************
  logic mm_r;
  logic [7:0] nch_r;
  logic [31:0] quiet_r;
  always_ff @(posedge mclk) begin
    if (!nrst || (start && !busy)) begin
      mm_r <= mode_multi;
      nch_r <= 8'h00;
      quiet_r <= 32'h0;
    end else begin
      nch_r <= nch_r + 8'(rsp_valid);
      quiet_r <= (ser_tx_oe || !ser_rx) ? 32'h0 : quiet_r + 32'h1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  property p_idle_tx; !ser_tx_oe |-> ser_tx; endproperty
  a_idle_tx: assert property (p_idle_tx) else $error("line not idle high");
  property p_start_bit; $rose(busy) |=> !ser_tx && ser_tx_oe; endproperty
  a_start_bit: assert property (p_start_bit) else $error("no start bit after start");
  property p_done_busy; done |-> !busy && $past(busy); endproperty
  a_done_busy: assert property (p_done_busy) else $error("done outside session");
  property p_one_flag; done |-> $onehot({rsp_ok, err_rsp, err_fcs, err_tmo}); endproperty
  a_one_flag: assert property (p_one_flag) else $error("outcome flags not one-hot");
  property p_clr; $rose(busy) |-> !(rsp_ok || err_rsp || err_fcs || err_tmo); endproperty
  a_clr: assert property (p_clr) else $error("flags not cleared at start");
  // Timeout runs from the last load or received char; the line is quiet one character plus one cycle after the load
  property p_tmo; $rose(err_tmo) |-> quiet_r + 32'(baud_div) * 32'hA + 32'h1 >= TMO_CYC; endproperty
  a_tmo: assert property (p_tmo) else $error("timeout too early");
  property p_gap; rsp_valid |=> !rsp_valid [*8]; endproperty
  a_gap: assert property (p_gap) else $error("reply chars too close");
  property p_len; done && rsp_ok |-> nch_r >= (mm_r ? 8'h07 : 8'h02); endproperty
  a_len: assert property (p_len) else $error("good reply too short");
  property p_no_rx_tx; ser_tx_oe |-> !rsp_valid; endproperty
  a_no_rx_tx: assert property (p_no_rx_tx) else $error("reply char while sending");
endmodule : hlf_chk_asserts

bind hlf_host hlf_chk_asserts #(.TMO_CYC(TMO_CYC)) u_chk (
  .mclk(mclk),
  .nrst(nrst),
  .baud_div(baud_div),
  .start(start),
  .mode_multi(mode_multi),
  .station_id(station_id),
  .cmd_we(cmd_we),
  .cmd_wdata(cmd_wdata),
  .ser_rx(ser_rx),
  .ser_tx(ser_tx),
  .ser_tx_oe(ser_tx_oe),
  .busy(busy),
  .done(done),
  .rsp_valid(rsp_valid),
  .rsp_data(rsp_data),
  .rsp_ok(rsp_ok),
  .err_rsp(err_rsp),
  .err_fcs(err_fcs),
  .err_tmo(err_tmo)
);

// [hlf_dev_model.sv]
`timescale 1ns/1ns
module hlf_dev_model (
  input wire logic mclk,
  input wire logic [15:0] baud_div,
  input wire logic line,
  input wire logic [7:0] own_id,
  input wire logic [1:0] err_mode,
  input wire logic [7:0] gap,
  output logic ser_rx
);
  // ****************************************
  // Behavioural controller, auto protocol mode
  // ****************************************
  logic [7:0] cap[$];
  logic [7:0] rq[$];
  logic [7:0] c;
  logic [7:0] f;
  logic bad;
  int n;
  function automatic logic [7:0] hx(input logic [3:0] v);
    return (v < 4'hA) ? 8'h30 + 8'(v) : 8'h37 + 8'(v);
  endfunction : hx
  function automatic logic [7:0] hb(input logic [7:0] a, input logic [7:0] b);
    return {4'(a - (a > 8'h39 ? 8'h37 : 8'h30)), 4'(b - (b > 8'h39 ? 8'h37 : 8'h30))};
  endfunction : hb
  task automatic get(output logic [7:0] ch);
    wait (line === 1'b1);
    wait (line === 1'b0);
    repeat (baud_div / 2) @(posedge mclk);
    for (int i = 0; i < 9; i++) begin
      repeat (baud_div) @(posedge mclk);
      if (i < 8) ch[i] = line;
    end
  endtask : get
  task automatic put(input logic [7:0] ch);
    for (int i = 0; i < 10; i++) begin
      ser_rx <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : ch[i - 1];
      repeat (baud_div) @(posedge mclk);
    end
  endtask : put
  initial begin
    ser_rx = 1'b1;
    forever begin
      get(c);
      cap.delete();
      rq.delete();
      if (c == 8'h40) cap.push_back(c);
      // Echo runs in the background: the host starts its frame before the echo stop bit ends
      if (c == 8'h05) begin
        fork
          put(8'h05);
        join_none
      end
      if (c == 8'h05 || c == 8'h40) begin
        do begin
          get(c);
          cap.push_back(c);
        end while (c != 8'h0D);
        n = cap.size();
        if (cap[0] != 8'h40) begin
          rq = {cap[0] ^ 8'(err_mode == 2'h1), cap[1], 8'h35, 8'h41};
        end else if (hb(cap[1], cap[2]) == own_id) begin
          f = 8'h00;
          for (int i = 0; i < n - 4; i++) f ^= cap[i];
          // Wildcard accepted since this model runs in auto mode
          bad = hb(cap[n - 4], cap[n - 3]) != f && hb(cap[n - 4], cap[n - 3]) != 8'h00;
          rq = {8'h40, hx(own_id[7:4]), hx(own_id[3:0]), cap[3] ^ 8'(bad || err_mode == 2'h1), cap[4], 8'h35, 8'h41};
          f = 8'(err_mode == 2'h2);
          foreach (rq[i]) f ^= rq[i];
          rq = {rq, hx(f[7:4]), hx(f[3:0])};
        end
        if (rq.size() > 0) begin
          repeat (gap) @(posedge mclk);
          foreach (rq[i]) put(rq[i]);
          put(8'h2A);
          put(8'h0D);
        end
      end
    end
  end
endmodule : hlf_dev_model

// [ascii_host_link_framer_tb.sv]
`timescale 1ns/1ns
module ascii_host_link_framer_tb;
  import hlf_pkg::*;
  // ****************************************
  // Bench signals and helpers
  // ****************************************
  localparam int unsigned TMO = 20000;
  logic mclk = 1'b0;
  logic nrst, start, mode_multi, cmd_we, ser_rx, ser_tx, ser_tx_oe, busy, done, rsp_valid;
  logic rsp_ok, err_rsp, err_fcs, err_tmo;
  logic [15:0] baud_div;
  logic [7:0] station_id, cmd_wdata, rsp_data, own_id, gap, rid;
  logic [1:0] err_mode;
  logic [7:0] rq[$];
  logic [7:0] ex[$];
  logic [7:0] body[$];
  int n_mismatch = 0;
  int cmp_count = 0;
  wire line_w = ser_tx_oe ? ser_tx : 1'b1;
  always #20 mclk = ~mclk;
  hlf_host #(.TMO_CYC(TMO)) uut (.mclk(mclk), .nrst(nrst), .baud_div(baud_div), .start(start),
    .mode_multi(mode_multi), .station_id(station_id), .cmd_we(cmd_we), .cmd_wdata(cmd_wdata),
    .ser_rx(ser_rx), .ser_tx(ser_tx), .ser_tx_oe(ser_tx_oe), .busy(busy), .done(done),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ok(rsp_ok), .err_rsp(err_rsp),
    .err_fcs(err_fcs), .err_tmo(err_tmo));
  hlf_dev_model dev (.mclk(mclk), .baud_div(baud_div), .line(line_w), .own_id(own_id),
    .err_mode(err_mode), .gap(gap), .ser_rx(ser_rx));
  always @(posedge mclk) if (rsp_valid === 1'b1) rq.push_back(rsp_data);
  function automatic logic [7:0] hx(input logic [3:0] v);
    return (v < 4'hA) ? 8'h30 + 8'(v) : 8'h37 + 8'(v);
  endfunction : hx
  function automatic logic [7:0] fcs(input logic [7:0] q[$]);
    fcs = 8'h00;
    foreach (q[i]) fcs ^= q[i];
  endfunction : fcs
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_of_test;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  task automatic session(input logic mm, input logic [7:0] id, input logic [7:0] own, input logic [1:0] em,
    input int len);
    logic [7:0] f;
    logic hit;
    body.delete();
    rq.delete();
    hit = !mm || own == id;
    for (int i = 0; i < len; i++) body.push_back(8'h41 + 8'($urandom % 26));
    foreach (body[i]) begin
      cmd_we <= 1'b1;
      cmd_wdata <= body[i];
      @(posedge mclk);
    end
    cmd_we <= 1'b0;
    mode_multi <= mm;
    station_id <= id;
    own_id <= own;
    err_mode <= em;
    gap <= 8'($urandom % 40);
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    repeat (3 * TMO) begin
      @(negedge mclk);
      if (done === 1'b1) break;
    end
    chk("done", done, 1'b1);
    ex.delete();
    if (mm) ex = {8'h40, hx(id[7:4]), hx(id[3:0])};
    ex = {ex, body};
    f = fcs(ex);
    if (mm) ex = {ex, hx(f[7:4]), hx(f[3:0])};
    ex = {ex, 8'h2A, 8'h0D};
    chk("frame_len", 32'(dev.cap.size()), 32'(ex.size()));
    foreach (ex[i]) chk("frame_char", dev.cap[i], ex[i]);
    chk("rsp_ok", rsp_ok, hit && (em == 2'h0 || (em == 2'h2 && !mm)));
    chk("err_rsp", err_rsp, hit && em == 2'h1);
    chk("err_fcs", err_fcs, hit && mm && em == 2'h2);
    chk("err_tmo", err_tmo, !hit);
    if (hit && em != 2'h1) begin
      ex.delete();
      if (mm) ex = {8'h40, hx(id[7:4]), hx(id[3:0])};
      ex = {ex, body[0], body[1], 8'h35, 8'h41};
      f = fcs(ex) ^ 8'(em == 2'h2);
      if (mm) ex = {ex, hx(f[7:4]), hx(f[3:0])};
      chk("rsp_len", 32'(rq.size()), 32'(ex.size()));
      foreach (ex[i]) chk("rsp_char", rq[i], ex[i]);
    end
    // Model is still in the closing stop bit when done pulses
    repeat (baud_div) @(posedge mclk);
  endtask : session
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    nrst = 1'b0;
    baud_div = 16'h0010;
    start = 1'b0;
    mode_multi = 1'b0;
    station_id = 8'h00;
    cmd_we = 1'b0;
    cmd_wdata = 8'h00;
    own_id = 8'h00;
    err_mode = 2'h0;
    gap = 8'h00;
    rid = 8'($urandom(32'h4EC4));
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    @(negedge mclk);
    chk("idle_tx", {ser_tx, ser_tx_oe, busy}, 3'h4);
    @(posedge mclk);
    session(1'b1, 8'h00, 8'h00, 2'h0, 2);
    session(1'b1, 8'hFF, 8'hFF, 2'h2, 6);
    session(1'b0, 8'h00, 8'h00, 2'h1, 3);
    session(1'b1, 8'h12, 8'h13, 2'h0, 3);
    // Slower line rate, changed only while idle
    baud_div <= 16'h0018;
    session(1'b0, 8'h00, 8'h00, 2'h0, 4);
    baud_div <= 16'h0010;
    for (int k = 0; k < 6; k++) begin
      rid = 8'($urandom);
      session(1'($urandom), rid, rid, 2'($urandom % 3), 2 + int'($urandom % 5));
    end
    end_of_test();
  end
  initial begin
    repeat (90000) @(posedge mclk);
    n_mismatch++;
    end_of_test();
  end
endmodule : ascii_host_link_framer_tb
